/* shared/cvsd_pkg.sv */
// constants and carrier types of the delta-modulation bit sequencer
// assumes a 200 MHz system clock that oversamples the codec clock pin
package cvsd_pkg;

    // system clock rate
    localparam int CLK_MHZ = 200;

    // history register lengths of the two variants
    localparam int HIST_LEN_LOW = 3;
    localparam int HIST_LEN_HIGH = 4;

    // least codec clock pulse widths and data window, in ns
    localparam int CLK_HIGH_MIN_NS = 300;
    localparam int CLK_LOW_MIN_NS = 900;
    localparam int DATA_SETUP_NS = 500;
    localparam int DATA_HOLD_NS = 500;

    // the same as whole system clock cycles, rounded up
    localparam int CLK_HIGH_MIN_CYC = (CLK_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CLK_LOW_MIN_CYC = (CLK_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_HOLD_CYC = (DATA_HOLD_NS * CLK_MHZ + 999) / 1000;

    // width of the timing counters, holds the largest count above
    localparam int TCNT_W = 8;

    // synchroniser depth and stream buffer shape
    localparam int SYNC_STAGES = 2;
    localparam int FIFO_DEPTH = 16;

    // reset values
    localparam logic SERIAL_RESET = 1'b0;
    localparam logic COINC_RESET = 1'b1;

    // pins sampled from outside the clock domain
    typedef struct packed {
        logic codecClk;
        logic encodeSel;
        logic dataIn;
        logic compHigh;
    } pins_t;

    localparam int PIN_COUNT = $bits(pins_t);

    // one captured bit with its side information
    typedef struct packed {
        logic serialBit;
        logic slopeUp;
        logic coincident;
    } sample_t;

    localparam int SAMPLE_W = $bits(sample_t);

    // sticky fault flags
    typedef struct packed {
        logic highWidth;
        logic lowWidth;
        logic setup;
        logic hold;
        logic overrun;
    } fault_t;

    // codec clock phase tracker
    typedef enum logic [1:0] {
        PH_UNKNOWN,
        PH_HIGH,
        PH_LOW
    } phase_t;

endpackage

/* hw/bit_fifo.sv */
// first-in first-out buffer with a registered output stage
// assumes one clock, DEPTH a power of two, and a shared clock enable
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clkEn,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [CW-1:0] count_r;
    logic [WIDTH-1:0] head_r;
    logic headValid_r;
    logic push;
    logic pop;

    assign inReady = (count_r != CW'(DEPTH));
    assign push = inValid && inReady;
    assign pop = (count_r != '0) && (!headValid_r || outReady);
    assign outValid = headValid_r;
    assign outData = head_r;

    // storage
    always_ff @(posedge clock) begin
        if (clkEn && push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (clkEn) begin
            if (push) begin
                wrPtr_r <= AW'(wrPtr_r + 1'b1);
            end
            if (pop) begin
                rdPtr_r <= AW'(rdPtr_r + 1'b1);
            end
            if (push && !pop) begin
                count_r <= CW'(count_r + 1'b1);
            end else if (pop && !push) begin
                count_r <= CW'(count_r - 1'b1);
            end
        end
    end

    // output register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            head_r <= '0;
            headValid_r <= 1'b0;
        end else if (clkEn) begin
            if (pop) begin
                head_r <= mem[rdPtr_r];
                headValid_r <= 1'b1;
            end else if (outReady) begin
                headValid_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/cvsd_bit_sequencer.sv */
// digital core of a slope delta codec: history, coincidence, slope
// assumes the codec clock and logic pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module cvsd_bit_sequencer
    import cvsd_pkg::*;
#(
    parameter int HIST_LEN = cvsd_pkg::HIST_LEN_HIGH,
    parameter int DEPTH = cvsd_pkg::FIFO_DEPTH
) (
    // clock, reset and clock enable
    input wire logic clock,
    input wire logic resetn,
    input wire logic clkEn,
    // asynchronous codec pins
    input wire cvsd_pkg::pins_t pinsIn,
    // serial bit and slope direction
    output logic serialOut,
    output logic slopeUp,
    // open-drain coincidence pin
    output logic coincOut,
    output logic coincOe,
    // captured bit stream
    output logic sampleValid,
    input wire logic sampleReady,
    output cvsd_pkg::sample_t sampleOut,
    // status
    output logic idlePattern,
    output cvsd_pkg::fault_t faults,
    input wire cvsd_pkg::fault_t faultClear
);
    import cvsd_pkg::*;

    localparam int RUN_W = $clog2(HIST_LEN + 1);
    // one sticky flag per fault
    localparam int FAULT_W = $bits(fault_t);

    // synchronised pins
    logic [PIN_COUNT-1:0] syncA_r;
    logic [PIN_COUNT-1:0] syncB_r;
    pins_t pinsSync;

    // edge detection
    logic codecClkPrev_r;
    logic dataPrev_r;
    logic fallEdge;
    logic riseEdge;
    logic dataChange;

    // mode candidates
    logic encBit;
    logic decBit;

    // capture path
    logic capBit;
    logic [HIST_LEN-1:0] history_r;
    logic [HIST_LEN-1:0] historyNxt;
    logic serial_r;
    logic slope_r;
    logic coinc_r;
    logic coincNxt;

    // alternation tracking
    logic [RUN_W-1:0] altRun_r;
    logic idle_r;

    // timing checks
    phase_t phase_r;
    logic [TCNT_W-1:0] phaseCnt_r;
    logic [TCNT_W-1:0] stableCnt_r;
    logic [TCNT_W-1:0] holdCnt_r;
    logic decodeEdge;

    // faults and stream
    fault_t fault_r;
    fault_t faultSet;
    logic fifoReady;
    logic fifoPush;
    sample_t sampleNxt;

    // two-flip-flop synchroniser per pin
    generate
        for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    syncA_r[i] <= 1'b0;
                    syncB_r[i] <= 1'b0;
                end else if (clkEn) begin
                    syncA_r[i] <= pinsIn[i];
                    syncB_r[i] <= syncA_r[i];
                end
            end
        end
    endgenerate

    assign pinsSync = pins_t'(syncB_r);

    // previous values for edge detection
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            codecClkPrev_r <= 1'b0;
            dataPrev_r <= 1'b0;
        end else if (clkEn) begin
            codecClkPrev_r <= pinsSync.codecClk;
            dataPrev_r <= pinsSync.dataIn;
        end
    end

    // one-cycle pulse per codec clock edge and per data change
    assign fallEdge = codecClkPrev_r && !pinsSync.codecClk;
    assign riseEdge = !codecClkPrev_r && pinsSync.codecClk;
    assign dataChange = dataPrev_r != pinsSync.dataIn;
    assign decodeEdge = fallEdge && !pinsSync.encodeSel;

    // candidate bits of the two modes
    assign encBit = !pinsSync.compHigh;
    assign decBit = !pinsSync.dataIn;

    // bit selection by mode
    always_comb begin
        if (pinsSync.encodeSel) begin
            capBit = encBit;
        end else begin
            capBit = decBit;
        end
    end

    // next history, one stage per bit, newest in bit 0
    generate
        for (genvar j = 0; j < HIST_LEN; j++) begin : g_hist
            if (j == 0) begin : g_head
                assign historyNxt[j] = capBit;
            end else begin : g_tail
                assign historyNxt[j] = history_r[j-1];
            end

            // history shift register stage
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    history_r[j] <= 1'b0;
                end else if (clkEn && fallEdge) begin
                    history_r[j] <= historyNxt[j];
                end
            end
        end
    endgenerate

    // coincidence of the next history
    assign coincNxt = (&historyNxt) || !(|historyNxt);

    // serial output register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            serial_r <= SERIAL_RESET;
        end else if (clkEn && fallEdge) begin
            serial_r <= capBit;
        end
    end

    // slope direction, source when the taken bit is low
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            slope_r <= !SERIAL_RESET;
        end else if (clkEn && fallEdge) begin
            slope_r <= !capBit;
        end
    end

    // coincidence, updated with the history
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            coinc_r <= COINC_RESET;
        end else if (clkEn && fallEdge) begin
            coinc_r <= coincNxt;
        end
    end

    // run of alternating bits
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            altRun_r <= '0;
            idle_r <= 1'b0;
        end else if (clkEn && fallEdge) begin
            if (capBit != serial_r) begin
                if (altRun_r != RUN_W'(HIST_LEN)) begin
                    altRun_r <= RUN_W'(altRun_r + 1'b1);
                end
                idle_r <= (altRun_r >= RUN_W'(HIST_LEN - 1));
            end else begin
                altRun_r <= '0;
                idle_r <= 1'b0;
            end
        end
    end

    // codec clock phase tracker
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_r <= PH_UNKNOWN;
        end else if (clkEn) begin
            case (phase_r)
                PH_UNKNOWN: begin
                    if (riseEdge) begin
                        phase_r <= PH_HIGH;
                    end else if (fallEdge) begin
                        phase_r <= PH_LOW;
                    end
                end
                PH_HIGH: begin
                    if (fallEdge) begin
                        phase_r <= PH_LOW;
                    end
                end
                PH_LOW: begin
                    if (riseEdge) begin
                        phase_r <= PH_HIGH;
                    end
                end
                default: begin
                    phase_r <= PH_UNKNOWN;
                end
            endcase
        end
    end

    // cycles since the last codec clock edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phaseCnt_r <= '0;
        end else if (clkEn) begin
            if (riseEdge || fallEdge) begin
                phaseCnt_r <= '0;
            end else if (phaseCnt_r != '1) begin
                phaseCnt_r <= TCNT_W'(phaseCnt_r + 1'b1);
            end
        end
    end

    // cycles the data input has stood still
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stableCnt_r <= '0;
        end else if (clkEn) begin
            if (dataChange) begin
                stableCnt_r <= '0;
            end else if (stableCnt_r != '1) begin
                stableCnt_r <= TCNT_W'(stableCnt_r + 1'b1);
            end
        end
    end

    // hold window after a decode edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            holdCnt_r <= '0;
        end else if (clkEn) begin
            if (decodeEdge) begin
                holdCnt_r <= TCNT_W'(DATA_HOLD_CYC);
            end else if (holdCnt_r != '0) begin
                holdCnt_r <= TCNT_W'(holdCnt_r - 1'b1);
            end
        end
    end

    // fault events
    always_comb begin
        faultSet = '0;
        faultSet.highWidth = fallEdge && (phase_r == PH_HIGH) &&
            (phaseCnt_r < TCNT_W'(CLK_HIGH_MIN_CYC - 1));
        faultSet.lowWidth = riseEdge && (phase_r == PH_LOW) &&
            (phaseCnt_r < TCNT_W'(CLK_LOW_MIN_CYC - 1));
        faultSet.setup = decodeEdge &&
            (stableCnt_r < TCNT_W'(DATA_SETUP_CYC - 1));
        faultSet.hold = dataChange && (holdCnt_r != '0);
        faultSet.overrun = fallEdge && !fifoReady;
    end

    // sticky faults, one flag per bit, a new event beats a clear
    generate
        for (genvar k = 0; k < FAULT_W; k++) begin : g_fault
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    fault_r[k] <= 1'b0;
                end else if (clkEn) begin
                    fault_r[k] <= (fault_r[k] && !faultClear[k]) ||
                        faultSet[k];
                end
            end
        end
    endgenerate

    // captured bit with its side information
    always_comb begin
        sampleNxt.serialBit = capBit;
        sampleNxt.slopeUp = !capBit;
        sampleNxt.coincident = coincNxt;
    end

    // a capture offers one sample to the buffer
    assign fifoPush = clkEn && fallEdge;

    // stream buffer for captured bits
    bit_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .clkEn(clkEn),
        .inValid(fifoPush),
        .inReady(fifoReady),
        .inData(sampleNxt),
        .outValid(sampleValid),
        .outReady(sampleReady && clkEn),
        .outData(sampleOut)
    );

    // outputs
    assign serialOut = serial_r;
    assign slopeUp = slope_r;
    assign coincOut = 1'b0;
    assign coincOe = coinc_r;
    assign idlePattern = idle_r;
    assign faults = fault_r;
endmodule
`default_nettype wire

/* test/cvsd_link_model.sv */
// serial channel model: codec clock, data and comparator pins
// assumes the bench calls bitCycle once per codec bit
`timescale 1ns/1ps
`default_nettype none
module cvsd_link_model
    import cvsd_pkg::*;
#(
    parameter int HIGH_CYC = 120,
    parameter int LOW_CYC = 200
) (
    // clock and looped output
    input wire logic clock,
    input wire logic serialOut,
    // driven pins
    output logic codecClk,
    output logic dataIn,
    output logic compHigh
);
    initial begin
        codecClk = 1'b0;
        dataIn = 1'b0;
        compHigh = 1'b0;
    end

    // one codec period, data set up a whole high phase ahead
    task automatic bitCycle(input logic d, input logic c, input logic loop);
        @(posedge clock);
        codecClk <= 1'b1;
        dataIn <= loop ? serialOut : d;
        compHigh <= loop ? serialOut : c;
        repeat (HIGH_CYC) @(posedge clock);
        codecClk <= 1'b0;
        repeat (DATA_HOLD_CYC + 1) @(posedge clock);
        // hold over: lines no longer meaningful
        dataIn <= ~dataIn;
        compHigh <= ~compHigh;
        repeat (LOW_CYC - DATA_HOLD_CYC - 1) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* test/cvsd_bit_sequencer_monitor.sv */
// concurrent checks on the bit sequencer ports
// assumes one clock domain, bound into the design top
`timescale 1ns/1ps
`default_nettype none
module cvsd_bit_sequencer_monitor
    import cvsd_pkg::*;
#(
    parameter int HIST_LEN = HIST_LEN_HIGH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock, reset and enable
    input wire logic clock,
    input wire logic resetn,
    input wire logic clkEn,
    // codec pins and outputs
    input wire cvsd_pkg::pins_t pinsIn,
    input wire logic serialOut,
    input wire logic slopeUp,
    input wire logic coincOut,
    input wire logic coincOe,
    // stream and status
    input wire logic sampleValid,
    input wire logic sampleReady,
    input wire cvsd_pkg::sample_t sampleOut,
    input wire logic idlePattern,
    input wire cvsd_pkg::fault_t faults,
    input wire cvsd_pkg::fault_t faultClear
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // codec clock fall while running
    sequence pinFell;
        $fell(pinsIn.codecClk) && clkEn;
    endsequence
    // enable held over the capture latency
    sequence runOn;
        clkEn [*4];
    endsequence

    a_capture_value: assert property (
        pinFell ##2 runOn |-> serialOut ==
        (pinsIn.encodeSel ? !pinsIn.compHigh : !pinsIn.dataIn))
        else $error("serial bit differs from captured pin");
    a_serial_on_fall: assert property (
        $changed(serialOut) |->
        $past(pinsIn.codecClk, 6) && !$past(pinsIn.codecClk, 2))
        else $error("serial output moved away from a clock fall");
    a_freeze_hold: assert property (
        !clkEn |=> $stable(serialOut) && $stable(coincOe)
        && $stable(sampleValid))
        else $error("state moved while disabled");
    a_slope_inverse: assert property (slopeUp != serialOut)
        else $error("slope direction not inverse of output");
    a_coinc_change: assert property ($changed(serialOut) |-> !coincOe)
        else $error("coincidence with mixed history");
    a_coinc_drain: assert property (coincOut == 1'b0)
        else $error("coincidence pin drives high");
    a_stream_hold: assert property (
        sampleValid && !sampleReady |=> sampleValid && $stable(sampleOut))
        else $error("stalled sample changed");
    a_sample_pair: assert property (
        sampleValid |-> sampleOut.slopeUp != sampleOut.serialBit)
        else $error("sample slope not inverse of bit");
    a_reset_vals: assert property (
        $rose(resetn) |-> !serialOut && slopeUp && coincOe && !sampleValid)
        else $error("wrong values after reset");
    a_idle_coinc: assert property (idlePattern |-> !coincOe)
        else $error("idle pattern with coincidence");
    a_fault_sticky: assert property (
        faults.overrun && !faultClear.overrun |=> faults.overrun)
        else $error("overrun flag lost without a clear");
endmodule

bind cvsd_bit_sequencer cvsd_bit_sequencer_monitor #(
    .HIST_LEN(HIST_LEN),
    .DEPTH(DEPTH)
) u_mon (
    .clock(clock), .resetn(resetn), .clkEn(clkEn), .pinsIn(pinsIn),
    .serialOut(serialOut), .slopeUp(slopeUp), .coincOut(coincOut),
    .coincOe(coincOe), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleOut(sampleOut),
    .idlePattern(idlePattern), .faults(faults), .faultClear(faultClear)
);
`default_nettype wire

/* test/cvsd_bit_sequencer_tb.sv */
// self-checking bench of the delta codec bit sequencer
// assumes the link model and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module cvsd_bit_sequencer_tb;
    import cvsd_pkg::*;
    localparam int HL = HIST_LEN_HIGH;
    logic clock, resetn, clkEn, encodeSel, sampleReady, holdReady;
    logic serialOut, slopeUp, coincOut, coincOe, sampleValid, idlePattern;
    logic codecClk, dataIn, compHigh, expSer;
    logic [HL-1:0] hist;
    pins_t pinsIn;
    sample_t sampleOut;
    sample_t expQ[$];
    sample_t expS;
    fault_t faults, faultClear;
    int miscompares, cmp_count, cycles, seed, i;

    assign pinsIn = {codecClk, encodeSel, dataIn, compHigh};

    cvsd_link_model u_link (.clock(clock), .serialOut(serialOut),
        .codecClk(codecClk), .dataIn(dataIn), .compHigh(compHigh));

    cvsd_bit_sequencer #(.HIST_LEN(HL), .DEPTH(FIFO_DEPTH)) u_dut (
        .clock(clock), .resetn(resetn), .clkEn(clkEn), .pinsIn(pinsIn),
        .serialOut(serialOut), .slopeUp(slopeUp), .coincOut(coincOut),
        .coincOe(coincOe), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleOut(sampleOut),
        .idlePattern(idlePattern), .faults(faults),
        .faultClear(faultClear));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic checkBit(input string what, input logic exp,
                            input logic got);
        check(what, {7'h00, exp}, {7'h00, got});
    endtask

    // bit the sequencer should capture
    function automatic logic capBit(logic enc, logic d, logic c);
        return enc ? ~c : ~d;
    endfunction

    task automatic sendBit(input logic enc, input logic d, input logic c,
                           input logic loop);
        logic b;
        sample_t s;
        b = loop ? ~expSer : capBit(enc, d, c);
        encodeSel <= enc;
        hist = {hist[HL-2:0], b};
        expSer = b;
        s = '{b, ~b, (&hist) | ~(|hist)};
        if (expQ.size() < FIFO_DEPTH + 1)
            expQ.push_back(s);
        u_link.bitCycle(d, c, loop);
        checkBit("serialOut", b, serialOut);
        checkBit("slopeUp", ~b, slopeUp);
        checkBit("coincOe", s.coincident, coincOe);
    endtask

    task automatic resetDut();
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        hist = '0;
        expSer = 1'b0;
        expQ.delete();
        @(posedge clock);
        checkBit("serialOut", 1'b0, serialOut);
        checkBit("coincOe", 1'b1, coincOe);
        checkBit("sampleValid", 1'b0, sampleValid);
    endtask

    // random ready, timeout
    always @(posedge clock) begin
        sampleReady <= holdReady ? 1'b0 : 1'($random(seed));
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            conclude();
        end
    end

    // stream order and content
    always @(negedge clock) begin
        if (resetn && clkEn && sampleValid && sampleReady) begin
            if (expQ.size() == 0) begin
                check("sampleExtra", 8'h00, 8'h01);
            end else begin
                expS = expQ.pop_front();
                check("sampleOut", 8'(expS), 8'(sampleOut));
            end
        end
    end

    initial begin
        seed = 32'hF0438F56;
        resetn = 1'b0;
        clkEn = 1'b1;
        encodeSel = 1'b0;
        holdReady = 1'b0;
        faultClear = '0;
        resetDut();
        for (i = 0; i < 8; i++)
            sendBit(i[2], i[1], i[0], 1'b0);
        repeat (HL + 1)
            sendBit(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (HL + 1)
            sendBit(1'b0, 1'b0, 1'b1, 1'b0);
        checkBit("idlePattern", 1'b0, idlePattern);
        repeat (40)
            sendBit(1'($random(seed)), 1'($random(seed)),
                1'($random(seed)), 1'b0);
        repeat (2 * HL)
            sendBit(1'b0, 1'b0, 1'b0, 1'b1);
        checkBit("idlePattern", 1'b1, idlePattern);
        repeat (2 * HL)
            sendBit(1'b1, 1'b0, 1'b0, 1'b1);
        checkBit("idlePattern", 1'b1, idlePattern);
        clkEn <= 1'b0;
        u_link.bitCycle(expSer, expSer, 1'b0);
        checkBit("frozen", expSer, serialOut);
        clkEn <= 1'b1;
        holdReady <= 1'b1;
        @(posedge clock);
        repeat (FIFO_DEPTH + 3)
            sendBit(1'b1, 1'b0, 1'($random(seed)), 1'b0);
        checkBit("overrun", 1'b1, faults.overrun);
        holdReady <= 1'b0;
        repeat (200) @(posedge clock);
        check("drained", 8'h00, 8'(expQ.size()));
        checkBit("sampleValid", 1'b0, sampleValid);
        check("faultsOnlyOverrun", 8'h01, 8'(faults));
        faultClear <= '1;
        @(posedge clock);
        faultClear <= '0;
        @(posedge clock);
        check("faults", 8'h00, 8'(faults));
        resetDut();
        sendBit(1'b0, 1'b1, 1'b0, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
